// *** common/cke_regs.vh ***
// register map and protocol constants of the key field extractor
`ifndef CKE_REGS_VH
`define CKE_REGS_VH

`define CKE_CTRL_OFS        12'h000
`define CKE_STATUS_OFS      12'h004
`define CKE_RNG_TYPE_OFS    12'h010
`define CKE_RNG_BOUND_OFS   12'h020
`define CKE_RNG_BOUND_END   12'h03c

`define CKE_CTRL_USECL_BIT  0
`define CKE_STATUS_BUSY_BIT 16
`define CKE_CTRL_RESET      1'b0
`define CKE_RNG_TYPE_RESET  24'h000000
`define CKE_RNG_BOUND_RESET 32'h00000000

`define CKE_RNG_OFF         3'h0
`define CKE_RNG_SPORT       3'h1
`define CKE_RNG_DPORT       3'h2
`define CKE_RNG_ANYPORT     3'h3
`define CKE_RNG_VID         3'h4
`define CKE_RNG_DSCP        3'h5
`define CKE_RNG_CUSTOM      3'h6

`define CKE_FRAME_TYPE_WORD_MIN       16'h0600
`define CKE_FRAME_TYPE_WORD_IPV4      16'h0800
`define CKE_FRAME_TYPE_WORD_IPV6      16'h86dd
`define CKE_TPID_CTAG       16'h8100
`define CKE_TPID_STAG       16'h88a8
`define CKE_LLC_SNAP        8'haa
`define CKE_LLC_UI          8'h03
`define CKE_PROTO_TCP       8'h06
`define CKE_PROTO_UDP       8'h11
`define CKE_IPV4_MIN_IHL    4'h5
`define CKE_MAX_TAGS        2'h3
`define CKE_IPV6_HDR_LEN    11'h028

`endif

// *** logic/cke_byte_mem.v ***
// small byte memory holding the payload snapshot, registered read port
`default_nettype none
module cke_byte_mem #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire          clk,
  input  wire          ce,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [7:0]    wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [7:0]    rdData
);
  reg [7:0] mem [0:DEPTH-1];

  // no reset on the array; unwritten bytes are masked by the reader
  always @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule // cke_byte_mem
`default_nettype wire

// *** logic/cke_range_cell.v ***
// one range checker: compares a selected key input against a bound pair
`default_nettype none
`include "cke_regs.vh"
module cke_range_cell (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [2:0]  kind,
  input  wire [15:0] lower,
  input  wire [15:0] upper,
  input  wire [15:0] srcPort,
  input  wire [15:0] dstPort,
  input  wire [11:0] vid,
  input  wire [5:0]  dscp,
  input  wire [15:0] custom,
  output reg         hit
);
  function inRange;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      inRange = (v >= lo) && (v <= hi);
    end
  endfunction

  reg next_hit;

  always @* begin
    case (kind)
      `CKE_RNG_SPORT:   next_hit = inRange(srcPort, lower, upper);
      `CKE_RNG_DPORT:   next_hit = inRange(dstPort, lower, upper);
      `CKE_RNG_ANYPORT: next_hit = inRange(srcPort, lower, upper) | inRange(dstPort, lower, upper);
      `CKE_RNG_VID:     next_hit = inRange({4'h0, vid}, lower, upper);
      `CKE_RNG_DSCP:    next_hit = inRange({10'h000, dscp}, lower, upper);
      `CKE_RNG_CUSTOM:  next_hit = inRange(custom, lower, upper);
      default:          next_hit = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
    end else if (ce) begin
      hit <= next_hit;
    end
  end
endmodule // cke_range_cell
`default_nettype wire

// *** logic/cke_extractor.v ***
// frame parser filling the layer-3/4 and payload fields of the lookup key
`default_nettype none
`include "cke_regs.vh"
// Summary of operation
// - llc frames put dsap,ssap in type word; snap frames put pid bytes 4,3
// - ip frames put l4 destination port if tcp_or_udp_flag, else protocol number
// - other ethertype frames put the ethertype itself in the type word
// - ethertype frames flag ip when 0800 with v4 or 86dd with v6
// - length frames flag snap when llc header reads aa-aa-03
// - ipv4 flag only for ethertype 0800 with version 4
// - fragmented when more-fragments bit set or offset above zero
// - non-first-fragment when fragment offset above zero
// - options flag when header length above 5; options not parsed
// - dscp field from frame, or classified dscp when selected by software
// - destination ip field 128 bits; ipv4 address in bits 31:0
// - source field holds llc ctrl plus 15 bytes, or snap pid plus 13
// - source field holds ipv4/ipv6 source, else first 16 payload bytes
// - tcp-or-udp flag for protocol 6 or 17, forced for oam frames
// - tcp flag for protocol or next header 6
// - eight range checkers on ports, vid, remapped dscp or custom value
// - 64 payload bytes captured from the current frame pointer
// - ethernet frame type starts capture after macs, 0-3 tags, ethertype
// - ethertype encoded when type/length field at least 0600
module cke_extractor #(
  parameter SNAP_BYTES = 64,
  parameter SNAP_AW    = 6,
  parameter NUM_RANGES = 8
) (
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     ce,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [11:0]              paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  input  wire                     rxValid,
  input  wire                     rxSof,
  input  wire                     rxEof,
  input  wire [7:0]               rxData,
  output reg                      rxReady,
  input  wire                     ethFrameType,
  input  wire [10:0]              framePointer,
  input  wire [5:0]               classifiedDscp,
  input  wire [5:0]               remappedDscp,
  input  wire [11:0]              frameVid,
  input  wire                     oamFrame,
  output reg                      keyValid,
  output reg  [15:0]              frameTypeWord,
  output reg                      ethertypeEncodedFlag,
  output reg                      ipOrSnapFlag,
  output reg                      ipv4Flag,
  output reg                      fragmentedFlag,
  output reg                      nonFirstFragmentFlag,
  output reg                      headerOptionsFlag,
  output reg  [5:0]               dscpKeyField,
  output reg  [127:0]             destIpKeyField,
  output reg  [127:0]             srcIpKeyField,
  output reg                      tcpOrUdpFlag,
  output reg                      tcpFlag,
  output reg  [15:0]              l4SourcePortField,
  output reg  [NUM_RANGES-1:0]    rangeMatchMask,
  output reg  [SNAP_BYTES*8-1:0]  payloadSnapshotField
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_PARSE = 4'b0010;
  localparam ST_DRAIN = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg  [3:0]            state;
  reg                   useClassifiedDscp;
  reg  [3*NUM_RANGES-1:0]  rngKind;
  reg  [32*NUM_RANGES-1:0] rngBound;
  reg  [15:0]           frameCount;
  // parse working state
  reg  [10:0]           cnt;
  reg  [7:0]            prevByte;
  reg  [1:0]            tagCount;
  reg                   etypeDone;
  reg  [15:0]           frame_type_word;
  reg  [10:0]           l3Base;
  reg  [7:0]            dsap;
  reg  [7:0]            ssap;
  reg  [15:0]           pid43;
  reg                   snap;
  reg                   isV4;
  reg                   isV6;
  reg  [3:0]            ihl;
  reg                   moreFrag;
  reg  [12:0]           fragOfs;
  reg  [7:0]            proto;
  reg  [5:0]            dscpFrame;
  reg  [15:0]           sport;
  reg  [15:0]           dport;
  reg  [127:0]          sipWork;
  reg  [127:0]          dipWork;
  reg  [SNAP_BYTES-1:0] written;
  reg  [5:0]            clDscp;
  reg  [5:0]            rmDscp;
  reg  [11:0]           vidHold;
  reg                   oamHold;
  reg  [6:0]            drainCnt;
  wire [7:0]            memData;
  wire [NUM_RANGES-1:0] hits;

  wire        accept  = ce && rxValid && rxReady;
  wire        eDone   = rxSof ? 1'b0 : etypeDone;
  wire [1:0]  tags    = rxSof ? 2'h0 : tagCount;
  wire [10:0] idx     = rxSof ? 11'h000 : cnt;
  wire [10:0] rel     = idx - l3Base;
  wire [15:0] word    = {prevByte, rxData};
  wire        encNow  = frame_type_word >= `CKE_FRAME_TYPE_WORD_MIN;
  wire        v4Now   = (rel == 11'h000) ? (frame_type_word == `CKE_FRAME_TYPE_WORD_IPV4 && rxData[7:4] == 4'h4)
                                         : isV4;
  wire        v6Now   = (rel == 11'h000) ? (frame_type_word == `CKE_FRAME_TYPE_WORD_IPV6 && rxData[7:4] == 4'h6)
                                         : isV6;
  wire        snapNow = (rel == 11'h002) ? (dsap == `CKE_LLC_SNAP && ssap == `CKE_LLC_SNAP &&
                                            rxData == `CKE_LLC_UI) : snap;
  wire [10:0] l4Ofs   = isV6 ? `CKE_IPV6_HDR_LEN : {5'h00, ihl, 2'b00};
  wire        isIp    = isV4 | isV6;
  wire        tcpUdp  = proto == `CKE_PROTO_TCP || proto == `CKE_PROTO_UDP;

  // source and destination windows, relative to the layer-3 start
  reg  [10:0] sipLo;
  reg  [10:0] sipHi;
  reg  [10:0] dipLo;
  reg  [10:0] dipHi;
  always @* begin
    dipLo = 11'h7ff;
    dipHi = 11'h000;
    if (!encNow) begin
      sipLo = snapNow ? 11'h005 : 11'h002;
      sipHi = snapNow ? 11'h014 : 11'h011;
    end else if (v4Now) begin
      sipLo = 11'h00c;
      sipHi = 11'h00f;
      dipLo = 11'h010;
      dipHi = 11'h013;
    end else if (v6Now) begin
      sipLo = 11'h008;
      sipHi = 11'h017;
      dipLo = 11'h018;
      dipHi = 11'h027;
    end else begin
      sipLo = 11'h000;
      sipHi = 11'h00f;
    end
  end

  // payload capture start; ethernet type skips the layer-2 header
  wire [10:0] capStart = (ethFrameType ? l3Base : 11'h000) + framePointer;
  wire [10:0] capIdx   = idx - capStart;
  wire        capOk    = (!ethFrameType || eDone) && idx >= capStart &&
                         capIdx < SNAP_BYTES;
  wire        memWr    = accept && capOk;

  cke_byte_mem #(.DEPTH(SNAP_BYTES), .AW(SNAP_AW)) u_mem (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (memWr),
    .wrAddr (capIdx[SNAP_AW-1:0]),
    .wrData (rxData),
    .rdAddr (drainCnt[SNAP_AW-1:0]),
    .rdData (memData)
  );

  // type word per frame class
  reg [15:0] next_typeWord;
  always @* begin
    if (!encNow) begin
      next_typeWord = snap ? pid43 : {dsap, ssap};
    end else if (isIp) begin
      next_typeWord = (tcpUdp || oamHold) ? dport : {8'h00, proto};
    end else begin
      next_typeWord = frame_type_word;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_RANGES; g = g + 1) begin : g_rng
      cke_range_cell u_cell (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .kind    (rngKind[3*g +: 3]),
        .lower   (rngBound[32*g +: 16]),
        .upper   (rngBound[32*g+16 +: 16]),
        .srcPort (sport),
        .dstPort (dport),
        .vid     (vidHold),
        .dscp    (rmDscp),
        .custom  (next_typeWord),
        .hit     (hits[g])
      );
    end
  endgenerate

  // parse and drain
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      rxReady <= 1'b0;
      cnt <= 11'h000;
      prevByte <= 8'h00;
      tagCount <= 2'h0;
      etypeDone <= 1'b0;
      frame_type_word <= 16'h0000;
      l3Base <= 11'h000;
      dsap <= 8'h00;
      ssap <= 8'h00;
      pid43 <= 16'h0000;
      snap <= 1'b0;
      isV4 <= 1'b0;
      isV6 <= 1'b0;
      ihl <= 4'h0;
      moreFrag <= 1'b0;
      fragOfs <= 13'h0000;
      proto <= 8'h00;
      dscpFrame <= 6'h00;
      sport <= 16'h0000;
      dport <= 16'h0000;
      sipWork <= 128'h0;
      dipWork <= 128'h0;
      written <= {SNAP_BYTES{1'b0}};
      clDscp <= 6'h00;
      rmDscp <= 6'h00;
      vidHold <= 12'h000;
      oamHold <= 1'b0;
      drainCnt <= 7'h00;
      frameCount <= 16'h0000;
      keyValid <= 1'b0;
      frameTypeWord <= 16'h0000;
      ethertypeEncodedFlag <= 1'b0;
      ipOrSnapFlag <= 1'b0;
      ipv4Flag <= 1'b0;
      fragmentedFlag <= 1'b0;
      nonFirstFragmentFlag <= 1'b0;
      headerOptionsFlag <= 1'b0;
      dscpKeyField <= 6'h00;
      destIpKeyField <= 128'h0;
      srcIpKeyField <= 128'h0;
      tcpOrUdpFlag <= 1'b0;
      tcpFlag <= 1'b0;
      l4SourcePortField <= 16'h0000;
      rangeMatchMask <= {NUM_RANGES{1'b0}};
      payloadSnapshotField <= {SNAP_BYTES*8{1'b0}};
    end else if (ce) begin
      keyValid <= 1'b0;
      case (state)
        ST_IDLE, ST_PARSE: begin
          rxReady <= 1'b1;
          if (accept && (rxSof || state == ST_PARSE)) begin
            if (rxSof) begin
              tagCount <= 2'h0;
              etypeDone <= 1'b0;
              frame_type_word <= 16'h0000;
              l3Base <= 11'h7ff;
              snap <= 1'b0;
              isV4 <= 1'b0;
              isV6 <= 1'b0;
              moreFrag <= 1'b0;
              fragOfs <= 13'h0000;
              ihl <= 4'h0;
              proto <= 8'h00;
              dscpFrame <= 6'h00;
              sport <= 16'h0000;
              dport <= 16'h0000;
              sipWork <= 128'h0;
              dipWork <= 128'h0;
              written <= {SNAP_BYTES{1'b0}};
              state <= ST_PARSE;
            end
            cnt <= (idx == 11'h7ff) ? idx : idx + 11'h001;
            prevByte <= rxData;
            if (memWr) begin
              written[capIdx[SNAP_AW-1:0]] <= 1'b1;
            end
            // walk up to three tags before the ethertype
            if (!eDone && idx == {7'h00, tags, 2'b00} + 11'h00d) begin
              if ((word == `CKE_TPID_CTAG || word == `CKE_TPID_STAG) &&
                  tags != `CKE_MAX_TAGS) begin
                tagCount <= tags + 2'h1;
              end else begin
                frame_type_word <= word;
                etypeDone <= 1'b1;
                l3Base <= idx + 11'h001;
              end
            end
            if (eDone) begin
              if (rel >= sipLo && rel <= sipHi) begin
                sipWork <= {sipWork[119:0], rxData};
              end
              if (rel >= dipLo && rel <= dipHi) begin
                dipWork <= {dipWork[119:0], rxData};
              end
              if (!encNow) begin
                if (rel == 11'h000) dsap <= rxData;
                if (rel == 11'h001) ssap <= rxData;
                if (rel == 11'h002) snap <= snapNow;
                if (rel == 11'h003) pid43[15:8] <= rxData;
                if (rel == 11'h004) pid43[7:0] <= rxData;
              end else begin
                if (rel == 11'h000) begin
                  isV4 <= v4Now;
                  isV6 <= v6Now;
                  ihl <= rxData[3:0];
                  if (v6Now) dscpFrame[5:2] <= rxData[3:0];
                end
                if (rel == 11'h001) begin
                  if (isV4) dscpFrame <= rxData[7:2];
                  if (isV6) dscpFrame[1:0] <= rxData[7:6];
                end
                if (isV4 && rel == 11'h006) begin
                  moreFrag <= rxData[5];
                  fragOfs[12:8] <= rxData[4:0];
                end
                if (isV4 && rel == 11'h007) fragOfs[7:0] <= rxData;
                if ((isV4 && rel == 11'h009) || (isV6 && rel == 11'h006)) proto <= rxData;
                if (isIp && rel == l4Ofs) sport[15:8] <= rxData;
                if (isIp && rel == l4Ofs + 11'h001) sport[7:0] <= rxData;
                if (isIp && rel == l4Ofs + 11'h002) dport[15:8] <= rxData;
                if (isIp && rel == l4Ofs + 11'h003) dport[7:0] <= rxData;
              end
            end
            if (rxEof) begin
              clDscp <= classifiedDscp;
              rmDscp <= remappedDscp;
              vidHold <= frameVid;
              oamHold <= oamFrame;
              drainCnt <= 7'h00;
              rxReady <= 1'b0;
              state <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          // one cycle read latency, so byte n lands while address n+1 is issued
          drainCnt <= drainCnt + 7'h01;
          if (drainCnt != 7'h00) begin
            payloadSnapshotField <= {payloadSnapshotField[SNAP_BYTES*8-9:0],
                                     written[drainCnt[SNAP_AW-1:0] - 1'b1] ?
                                     memData : 8'h00};
          end
          if (drainCnt == SNAP_BYTES) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          frameTypeWord <= next_typeWord;
          ethertypeEncodedFlag <= encNow;
          ipOrSnapFlag <= encNow ? isIp : snap;
          ipv4Flag <= encNow & isV4;
          fragmentedFlag <= isV4 & (moreFrag | (fragOfs != 13'h0000));
          nonFirstFragmentFlag <= isV4 & (fragOfs != 13'h0000);
          headerOptionsFlag <= isV4 & (ihl > `CKE_IPV4_MIN_IHL);
          dscpKeyField <= useClassifiedDscp ? clDscp : dscpFrame;
          destIpKeyField <= dipWork;
          srcIpKeyField <= sipWork;
          tcpOrUdpFlag <= (isIp & tcpUdp) | oamHold;
          tcpFlag <= isIp & (proto == `CKE_PROTO_TCP);
          l4SourcePortField <= sport;
          rangeMatchMask <= hits;
          frameCount <= frameCount + 16'h0001;
          keyValid <= 1'b1;
          rxReady <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // apb slave: answer prepared in setup, pready high for one access cycle
  wire [11:0] bIdx     = paddr - `CKE_RNG_BOUND_OFS;
  wire        isBound  = paddr >= `CKE_RNG_BOUND_OFS && paddr <= `CKE_RNG_BOUND_END &&
                         paddr[1:0] == 2'b00;
  wire        mapped   = paddr == `CKE_CTRL_OFS || paddr == `CKE_STATUS_OFS ||
                         paddr == `CKE_RNG_TYPE_OFS || isBound;
  reg  [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (paddr == `CKE_CTRL_OFS) begin
      next_rdata[`CKE_CTRL_USECL_BIT] = useClassifiedDscp;
    end else if (paddr == `CKE_STATUS_OFS) begin
      next_rdata = {15'h0000, state != ST_IDLE, frameCount};
    end else if (paddr == `CKE_RNG_TYPE_OFS) begin
      next_rdata = {8'h00, rngKind};
    end else if (isBound) begin
      next_rdata = rngBound[32*bIdx[4:2] +: 32];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      useClassifiedDscp <= `CKE_CTRL_RESET;
      rngKind <= `CKE_RNG_TYPE_RESET;
      rngBound <= {NUM_RANGES{`CKE_RNG_BOUND_RESET}};
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h00000000;
      if (psel && penable && pready && pwrite) begin
        if (paddr == `CKE_CTRL_OFS) useClassifiedDscp <= pwdata[`CKE_CTRL_USECL_BIT];
        if (paddr == `CKE_RNG_TYPE_OFS) rngKind <= pwdata[23:0];
        if (isBound) rngBound[32*bIdx[4:2] +: 32] <= pwdata;
      end
    end
  end
endmodule // cke_extractor
`default_nettype wire

// *** verif/cke_extractor_monitor.sv ***
// assertion checker on the key field extractor ports
`default_nettype none
module cke_extractor_monitor (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         ce,
  input wire logic         rxValid,
  input wire logic         rxEof,
  input wire logic         rxReady,
  input wire logic         keyValid,
  input wire logic [15:0]  frameTypeWord,
  input wire logic         ethertypeEncodedFlag,
  input wire logic         ipOrSnapFlag,
  input wire logic         ipv4Flag,
  input wire logic         fragmentedFlag,
  input wire logic         nonFirstFragmentFlag,
  input wire logic         headerOptionsFlag,
  input wire logic [127:0] destIpKeyField,
  input wire logic         tcpOrUdpFlag,
  input wire logic         tcpFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire eofIn = rxValid && rxReady && rxEof && ce;

  drain_stall_a: assert property (eofIn |=> !rxReady [*8])
    else $error("bytes accepted during drain");
  key_latency_a: assert property (eofIn |-> ##67 keyValid)
    else $error("key late or missing after last byte");
  frag_order_a: assert property (keyValid && nonFirstFragmentFlag |-> fragmentedFlag)
    else $error("later fragment not marked fragmented");
  non_ip_flags_a: assert property (keyValid && !ipv4Flag |->
    !(fragmentedFlag || nonFirstFragmentFlag || headerOptionsFlag))
    else $error("fragment flags set on non ipv4 frame");
  ipv4_class_a: assert property (ipv4Flag |-> ipOrSnapFlag && ethertypeEncodedFlag)
    else $error("ipv4 flag without ip class");
  tcp_subset_a: assert property (tcpFlag |-> tcpOrUdpFlag)
    else $error("tcp flag without tcp-or-udp flag");
  dest_upper_a: assert property (keyValid && ipv4Flag |-> destIpKeyField[127:32] == 96'h0)
    else $error("ipv4 destination above bit 31");
  frame_type_word_min_a: assert property (keyValid && ethertypeEncodedFlag && !ipOrSnapFlag
    |-> frameTypeWord >= 16'h0600)
    else $error("ethertype below 0600 in type word");
endmodule // cke_extractor_monitor

bind cke_extractor cke_extractor_monitor mon_u (.clk, .rst, .ce, .rxValid, .rxEof, .rxReady,
  .keyValid, .frameTypeWord, .ethertypeEncodedFlag, .ipOrSnapFlag, .ipv4Flag, .fragmentedFlag,
  .nonFirstFragmentFlag, .headerOptionsFlag, .destIpKeyField, .tcpOrUdpFlag, .tcpFlag);
`default_nettype wire

// *** verif/cke_key_sink.sv ***
// lookup engine stand-in that takes every key presented
`default_nettype none
module cke_key_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic keyValid,
  output var int   keyCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // the engine never stalls, so each pulse is one lookup
  always @(posedge clk or posedge rst)
    if (rst)
      keyCount <= 0;
    else if (keyValid)
      keyCount <= keyCount + 1;
endmodule // cke_key_sink
`default_nettype wire

// *** verif/cke_extractor_tb.sv ***
// self-checking bench for the key field extractor
`default_nettype none
module cke_extractor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = 0;
  logic [31:0]  pwdata = 0, prdata, rdat;
  logic         pready, pslverr, rerr, rxValid = 0, rxSof = 0, rxEof = 0, rxReady;
  logic         ethFrameType = 1, oamFrame = 0, keyValid, ethertypeEncodedFlag, ipOrSnapFlag;
  logic         ipv4Flag, fragmentedFlag, nonFirstFragmentFlag, headerOptionsFlag;
  logic         tcpOrUdpFlag, tcpFlag;
  logic [7:0]   rxData = 0, rangeMatchMask, fr[$], l3[72];
  logic [10:0]  framePointer = 0;
  logic [5:0]   classifiedDscp = 0, remappedDscp = 0, dscpKeyField, rd;
  logic [11:0]  frameVid = 0, vd;
  logic [15:0]  frameTypeWord, l4SourcePortField, sp, dp, xType, lo[8], hi[8];
  logic [127:0] destIpKeyField, srcIpKeyField;
  logic [511:0] payloadSnapshotField;
  logic [2:0]   kd[8];
  logic [23:0]  kw;
  int           num_errors = 0, compares = 0, seed = 32'haa30, keyCount;

  cke_extractor dut_u (.*);
  cke_key_sink sink_u (.clk, .rst, .keyValid, .keyCount);

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [511:0] e, input logic [511:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic send;
    for (int i = 0; i < fr.size(); i++) begin
      rxValid <= 1;
      rxSof <= (i == 0);
      rxEof <= (i == fr.size() - 1);
      rxData <= fr[i];
      do @(posedge clk); while (rxReady !== 1'b1);
    end
    rxValid <= 0;
    rxEof <= 0;
  endtask

  function automatic logic [127:0] gb(input int s, input int n);
    logic [127:0] r;
    r = 0;
    for (int i = 0; i < n; i++)
      r = {r[119:0], l3[s+i]};
    return r;
  endfunction

  function automatic logic rh(input int i);
    logic [15:0] v;
    v = kd[i] == 1 ? sp : kd[i] == 2 ? dp : kd[i] == 4 ? {4'h0, vd} : kd[i] == 5 ? {10'h0, rd}
      : xType;
    if (kd[i] == 3)
      return (sp >= lo[i] && sp <= hi[i]) || (dp >= lo[i] && dp <= hi[i]);
    return kd[i] != 0 && v >= lo[i] && v <= hi[i];
  endfunction

  // frame kinds: ipv4 tcp, ipv4 udp, ipv4 other/oam, other ethertype or ipv6 tcp, llc, snap
  task automatic run(input int n);
    int           t, tags, o, b;
    logic         mf, tu, v6;
    logic [12:0]  fo;
    logic [3:0]   ihl;
    logic [5:0]   cd;
    logic [7:0]   pr, xf, mk;
    logic [15:0]  et;
    logic [127:0] xsip;
    logic [511:0] xs;
    t = n % 6;
    v6 = t == 3 && n > 6;
    tags = n % 4;
    b = n % 3 == 2 ? 4 : 0;
    ihl = n % 2 ? 4'h6 : 4'h5;
    o = v6 ? 20 : n % 2 ? 4 : 0;
    fo = n % 4 == 0 ? 13'h0 : 13'($random(seed));
    {mf, cd, vd, rd} = $random(seed);
    for (int i = 0; i < 72; i++)
      l3[i] = $random(seed);
    pr = t == 0 || v6 ? 8'h06 : t == 1 ? 8'h11 : 8'h01;
    et = t < 3 ? 16'h0800 : v6 ? 16'h86dd : t == 3 ? 16'(16'h9000 | $random(seed)) : 16'h0040;
    if (t < 3) begin
      l3[0] = {4'h4, ihl};
      l3[6] = {2'b0, mf, fo[12:8]};
      l3[7] = fo[7:0];
      l3[9] = pr;
    end
    if (v6) begin
      l3[0][7:4] = 4'h6;
      l3[6] = pr;
    end
    l3[0] = t == 4 ? 8'h42 : t == 5 ? 8'haa : l3[0];
    l3[1] = t == 5 ? 8'haa : l3[1];
    l3[2] = t == 5 ? 8'h03 : l3[2];
    tu = t < 2 || v6 || (t == 2 && n > 6);
    sp = {l3[20+o], l3[21+o]};
    dp = {l3[22+o], l3[23+o]};
    xType = t < 3 || v6 ? (tu ? dp : {8'h0, pr}) : t == 3 ? et : {l3[(t-4)*3], l3[(t-4)*3+1]};
    xf = t < 3 ? {3'b111, mf || fo != 0, fo != 0, ihl > 5, tu, t == 0} : t == 5 ? 8'h40
      : v6 ? 8'hc3 : t == 3 ? 8'h80 : 8'h00;
    xsip = t < 3 ? gb(12, 4) : v6 ? gb(8, 16) : t == 3 ? gb(0, 16) : gb((t - 4) * 3 + 2, 16);
    for (int i = 0; i < 64; i++)
      xs = {xs[503:0], l3[b+i]};
    for (int i = 0; i < 8; i++)
      mk[i] = rh(i);
    // inputs are stable for the whole frame, as the parser expects
    oamFrame <= (t == 2 && n > 6);
    classifiedDscp <= cd;
    remappedDscp <= rd;
    frameVid <= vd;
    ethFrameType <= n % 3 != 1;
    framePointer <= n % 3 == 1 ? 11'(14 + 4 * tags) : 11'(b);
    fr = {};
    for (int i = 0; i < 12; i++)
      fr.push_back(8'($random(seed)));
    for (int i = 0; i < tags; i++)
      fr = {fr, i % 2 ? 8'h88 : 8'h81, i % 2 ? 8'ha8 : 8'h00, 8'h00, 8'h05};
    fr = {fr, et[15:8], et[7:0]};
    for (int i = 0; i < 72; i++)
      fr.push_back(l3[i]);
    send();
    for (int i = 0; i < 200 && keyValid !== 1'b1; i++)
      @(negedge clk);
    chk("key", 1, keyValid);
    chk("type", xType, frameTypeWord);
    chk("flags", xf, {ethertypeEncodedFlag, ipOrSnapFlag, ipv4Flag, fragmentedFlag,
      nonFirstFragmentFlag, headerOptionsFlag, tcpOrUdpFlag, tcpFlag});
    chk("snapshot", xs, payloadSnapshotField);
    chk("source ip", xsip, srcIpKeyField);
    if (t < 3 || v6) begin
      chk("dscp", n % 4 == 1 ? cd : v6 ? {l3[0][3:0], l3[1][7:6]} : l3[1][7:2],
        dscpKeyField);
      chk("dest ip", v6 ? gb(24, 16) : gb(16, 4), destIpKeyField);
    end
    if (t < 2 || v6)
      chk("range", mk, rangeMatchMask);
    chk("sport", t < 3 || v6 ? sp : 16'h0, l4SourcePortField);
    @(posedge clk);
  endtask

  task close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("idle key", 0, keyValid);
    apb(1, 12'h000, 1);
    apb(0, 12'h000, 0);
    chk("ctrl", 1, rdat);
    apb(0, 12'h0f0, 0);
    chk("unmapped", 33'h100000000, {rerr, rdat});
    // every range kind once and off twice, bounds random so hits and misses mix
    for (int i = 0; i < 8; i++) begin
      kd[i] = 3'(i % 7);
      kw[3*i+:3] = kd[i];
      lo[i] = 16'($random(seed)) & 16'h001f;
      hi[i] = 16'($random(seed));
      apb(1, 12'h020 + 12'(4 * i), {hi[i], lo[i]});
    end
    apb(1, 12'h010, {8'h0, kw});
    for (int n = 0; n < 18; n++) begin
      apb(1, 12'h000, 32'(n % 4 == 1));
      run(n);
    end
    @(negedge clk);
    chk("keys", 18, keyCount);
    close_out();
  end

  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule // cke_extractor_tb
`default_nettype wire
